// [hw/bridge_window_mapping.v]
`timescale 1ns/1ps
`default_nettype none
`include "bridge_window_consts.vh"

// ----------------------------------------
// Byte-wide write-only register slice
// ----------------------------------------
// One byte of a host register, loaded on its lane strobe
module bwm_byte_reg #(
    parameter [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Lane write
    input wire load_i,
    input wire [7:0] data_i,
    // Stored value
    output reg [7:0] value_o
);

    // Load on strobe, back to reset value on hard reset
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= RST_VAL;
        end else if (load_i) begin
            value_o <= data_i;
        end
    end

endmodule // bwm_byte_reg

// Behaviour
// - Wide cycles: host bits 23-20 are bus bits 23-20 plus the 4-bit offset.
// - Carry of the offset sum is dropped; offset acts two's complement.
// - Offset relocates in 1 MB steps; cleared on hard reset.
// - Wide enable set: wide hits make host memory cycles; cleared on reset.
// - Wide size field m gives window of 2^(24-m) bytes.
// - Short enable set: short hits make host I/O; else only config quarter.
// - Short size field n gives window of 2^(16-n) bytes.
// - Mapping register at offset 02, page at 04; write-only, byte or word.
// - Master transfers drive page bits 15-8 on bus lines 31-24.
// - Master transfers drive page bits 7-0 on bus lines 23-16.
// - Wide hit compares top m bits of address 23-17 with base.
// - Short hit compares top n bits of address 15-9 with base.
// - High byte sits at the odd address, low byte at the even one.
module bridge_window_mapping (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Host I/O write port
    input wire io_wr_i,
    input wire [3:0] io_addr_i,
    input wire io_byte_i,
    input wire [15:0] io_data_i,
    // Expansion bus slave side
    input wire slv_cycle_i,
    input wire slv_wide_i,
    input wire [23:0] slv_addr_i,
    // Expansion bus master side
    input wire mst_active_i,
    // Results
    output reg wide_hit_o,
    output reg short_hit_o,
    output reg cfg_hit_o,
    output reg host_mem_o,
    output reg host_io_o,
    output reg [23:0] host_addr_o,
    output reg [15:0] ad_upper_o,
    output reg ad_upper_oe_n_o
);

    // ----------------------------------------
    // Host write decode
    // ----------------------------------------
    // Lane of the access: odd address is the high byte
    wire odd_addr;
    wire [3:0] word_addr;
    wire wr_lo;
    wire wr_hi;
    wire [7:0] lo_data;
    wire [7:0] hi_data;
    assign odd_addr = io_addr_i[`ODD_BIT];
    assign word_addr = {io_addr_i[`WORD_HI:`WORD_LO], 1'b0};
    assign wr_lo = io_wr_i & ~(io_byte_i & odd_addr);
    assign wr_hi = io_wr_i & (~io_byte_i | odd_addr);
    // Byte write to odd address carries its data in the low lane
    assign lo_data = io_data_i[`LO_BYTE_HI:`LO_BYTE_LO];
    assign hi_data = (io_byte_i & odd_addr) ? io_data_i[`LO_BYTE_HI:`LO_BYTE_LO]
                                            : io_data_i[`HI_BYTE_HI:`HI_BYTE_LO];

    // Register selects; other offsets fall through unclaimed
    wire base_sel;
    wire map_sel;
    wire page_sel;
    assign base_sel = word_addr == `REG_BASE_OFS;
    assign map_sel = word_addr == `REG_MAP_OFS;
    assign page_sel = word_addr == `REG_PAGE_OFS;

    // Lane strobes per register
    wire base_lo_ld;
    wire base_hi_ld;
    wire map_lo_ld;
    wire map_hi_ld;
    wire page_lo_ld;
    wire page_hi_ld;
    assign base_lo_ld = base_sel & wr_lo;
    assign base_hi_ld = base_sel & wr_hi;
    assign map_lo_ld = map_sel & wr_lo;
    assign map_hi_ld = map_sel & wr_hi;
    assign page_lo_ld = page_sel & wr_lo;
    assign page_hi_ld = page_sel & wr_hi;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    // Assembled register words; there is no read path
    wire [15:0] base_addr;
    wire [15:0] window_map;
    wire [15:0] master_page;

    // Base register, low byte (short base)
    bwm_byte_reg #(
        .RST_VAL(`BASE_RST_LO)
    ) u_base_lo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(base_lo_ld),
        .data_i(lo_data),
        .value_o(base_addr[7:0])
    );
    // Base register, high byte (wide base)
    bwm_byte_reg #(
        .RST_VAL(`BASE_RST_HI)
    ) u_base_hi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(base_hi_ld),
        .data_i(hi_data),
        .value_o(base_addr[15:8])
    );
    // Mapping register, low byte (enables and sizes), cleared on reset
    bwm_byte_reg #(
        .RST_VAL(`MAP_RST_LO)
    ) u_map_lo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(map_lo_ld),
        .data_i(lo_data),
        .value_o(window_map[7:0])
    );
    // Mapping register, high byte (offset), cleared on reset
    bwm_byte_reg #(
        .RST_VAL(`MAP_RST_HI)
    ) u_map_hi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(map_hi_ld),
        .data_i(hi_data),
        .value_o(window_map[15:8])
    );
    // Page register, low byte (lines 23-16)
    bwm_byte_reg #(
        .RST_VAL(`PAGE_RST_LO)
    ) u_page_lo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(page_lo_ld),
        .data_i(lo_data),
        .value_o(master_page[7:0])
    );
    // Page register, high byte (lines 31-24)
    bwm_byte_reg #(
        .RST_VAL(`PAGE_RST_HI)
    ) u_page_hi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(page_hi_ld),
        .data_i(hi_data),
        .value_o(master_page[15:8])
    );

    // ----------------------------------------
    // Field views
    // ----------------------------------------
    wire [3:0] wide_window_offset;
    wire wide_window_enable;
    wire [2:0] wide_window_size;
    wire short_window_enable;
    wire [2:0] short_window_size;
    wire [6:0] slave_wide_base;
    wire [6:0] slave_short_base;
    wire [7:0] master_page_high;
    wire [7:0] master_page_low;

    // Mapping register fields; reserved bits are stored but unused
    assign wide_window_offset = window_map[`OFS_HI:`OFS_LO];
    assign wide_window_enable = window_map[`WEN_BIT];
    assign wide_window_size = window_map[`WSZ_HI:`WSZ_LO];
    assign short_window_enable = window_map[`SEN_BIT];
    assign short_window_size = window_map[`SSZ_HI:`SSZ_LO];
    // Base and page fields
    assign slave_wide_base = base_addr[`WBASE_HI:`WBASE_LO];
    assign slave_short_base = base_addr[`SBASE_HI:`SBASE_LO];
    assign master_page_high = master_page[`HI_BYTE_HI:`HI_BYTE_LO];
    assign master_page_low = master_page[`LO_BYTE_HI:`LO_BYTE_LO];

    // ----------------------------------------
    // Window decode
    // ----------------------------------------
    // Mask of the top m (or n) of seven compared bits; zero matches all
    function [6:0] top_mask;
        input [2:0] cnt;
        begin
            top_mask = ~(`MASK_ALL >> cnt);
        end
    endfunction

    // Address slices of the incoming cycle
    wire [6:0] wide_addr_bits;
    wire [6:0] short_addr_bits;
    wire [1:0] quarter_bits;
    wire [3:0] mb_bits;
    wire [19:0] mb_inner;
    wire [15:0] short_full;
    assign wide_addr_bits = slv_addr_i[`WADDR_HI:`WADDR_LO];
    assign short_addr_bits = slv_addr_i[`SADDR_HI:`SADDR_LO];
    assign quarter_bits = slv_addr_i[`QTR_HI:`QTR_LO];
    assign mb_bits = slv_addr_i[`MB_HI:`MB_LO];
    assign mb_inner = slv_addr_i[`INNER_HI:`INNER_LO];
    assign short_full = slv_addr_i[`SHORT_HI:`SHORT_LO];

    // Masks and matches against the base register
    wire [6:0] wide_mask;
    wire [6:0] short_mask;
    wire wide_match;
    wire short_match;
    wire cfg_match;
    wire [3:0] host_top;
    assign wide_mask = top_mask(wide_window_size);
    assign short_mask = top_mask(short_window_size);
    assign wide_match = ((wide_addr_bits ^ slave_wide_base) & wide_mask) == `MATCH_NONE;
    assign short_match = ((short_addr_bits ^ slave_short_base) & short_mask) == `MATCH_NONE;
    assign cfg_match = quarter_bits == `CFG_QUARTER;
    // Four-bit sum: the carry falls off, so the offset may move down
    assign host_top = mb_bits + wide_window_offset;

    // Qualified claims ahead of the output flops
    wire short_cyc;
    wire wide_claim;
    wire short_claim;
    wire cfg_claim;
    wire [23:0] next_host_addr;
    assign short_cyc = slv_cycle_i & ~slv_wide_i;
    assign wide_claim = slv_cycle_i & slv_wide_i & wide_window_enable & wide_match;
    assign cfg_claim = short_cyc & cfg_match;
    assign short_claim = short_cyc & ~cfg_match & short_window_enable & short_match;
    // Relocated address for wide cycles, plain for short ones
    assign next_host_addr = slv_wide_i ? {host_top, mb_inner} : {`SHORT_PAD, short_full};

    // ----------------------------------------
    // Slave results
    // ----------------------------------------
    // Registered claim flags and host address
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wide_hit_o <= 1'b0;
            short_hit_o <= 1'b0;
            cfg_hit_o <= 1'b0;
            host_mem_o <= 1'b0;
            host_io_o <= 1'b0;
            host_addr_o <= 24'h000000;
        end else begin
            wide_hit_o <= wide_claim;
            host_mem_o <= wide_claim;
            cfg_hit_o <= cfg_claim;
            short_hit_o <= short_claim;
            host_io_o <= short_claim;
            host_addr_o <= next_host_addr;
        end
    end

    // ----------------------------------------
    // Master address drive
    // ----------------------------------------
    // Page onto the upper lines; enable low while a master transfer runs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ad_upper_o <= 16'h0000;
            ad_upper_oe_n_o <= 1'b1;
        end else begin
            ad_upper_o <= {master_page_high, master_page_low};
            ad_upper_oe_n_o <= ~mst_active_i;
        end
    end

endmodule // bridge_window_mapping
`default_nettype wire

// [hw/bridge_window_consts.vh]
`ifndef BRIDGE_WINDOW_CONSTS_VH
`define BRIDGE_WINDOW_CONSTS_VH
// ----------------------------------------
// Register offsets (host I/O, from base)
// ----------------------------------------
`define REG_BASE_OFS 4'h0
`define REG_MAP_OFS 4'h2
`define REG_PAGE_OFS 4'h4
// ----------------------------------------
// Mapping register fields
// ----------------------------------------
`define OFS_HI 11
`define OFS_LO 8
`define WEN_BIT 7
`define WSZ_HI 6
`define WSZ_LO 4
`define SEN_BIT 3
`define SSZ_HI 2
`define SSZ_LO 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MAP_RST 16'h0000
`define PAGE_RST 16'h0000
`define BASE_RST 16'h0000
`define MAP_RST_HI 8'h00
`define MAP_RST_LO 8'h00
`define PAGE_RST_HI 8'h00
`define PAGE_RST_LO 8'h00
`define BASE_RST_HI 8'h00
`define BASE_RST_LO 8'h00
// ----------------------------------------
// Byte lanes and address slices
// ----------------------------------------
`define ODD_BIT 0
`define WORD_HI 3
`define WORD_LO 1
`define HI_BYTE_HI 15
`define HI_BYTE_LO 8
`define LO_BYTE_HI 7
`define LO_BYTE_LO 0
`define WBASE_HI 15
`define WBASE_LO 9
`define SBASE_HI 7
`define SBASE_LO 1
`define WADDR_HI 23
`define WADDR_LO 17
`define SADDR_HI 15
`define SADDR_LO 9
`define QTR_HI 15
`define QTR_LO 14
`define MB_HI 23
`define MB_LO 20
`define INNER_HI 19
`define INNER_LO 0
`define SHORT_HI 15
`define SHORT_LO 0
`define MASK_ALL 7'h7F
`define MATCH_NONE 7'h00
`define SHORT_PAD 8'h00
// Top quarter of short space holds config registers
`define CFG_QUARTER 2'h3
`endif

// [tb/bridge_window_mapping_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module bwm_props (
    input wire clk_i, rst_n_i, io_wr_i, io_byte_i, slv_cycle_i, slv_wide_i, mst_active_i,
    input wire [3:0] io_addr_i,
    input wire [15:0] io_data_i, ad_upper_o,
    input wire [23:0] slv_addr_i, host_addr_o,
    input wire wide_hit_o, short_hit_o, cfg_hit_o, host_mem_o, host_io_o, ad_upper_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Short cycle, and short address in the config quarter
    wire sc = slv_cycle_i && !slv_wide_i;
    wire cq = slv_addr_i[15:14] == 2'h3;
    wide_src_a:
    assert property (wide_hit_o |-> $past(slv_cycle_i && slv_wide_i)) else $error("wide src");
    host_req_a:
    assert property (host_mem_o == wide_hit_o && host_io_o == short_hit_o) else $error("req");
    wide_low_a:
    assert property (wide_hit_o |-> host_addr_o[19:0] == $past(slv_addr_i[19:0]))
        else $error("wide low");
    short_src_a:
    assert property (short_hit_o |-> $past(sc && !cq)) else $error("short src");
    cfg_claim_a:
    assert property (sc && cq |=> cfg_hit_o && !short_hit_o) else $error("cfg");
    short_addr_a:
    assert property (short_hit_o |-> host_addr_o == {8'h00, $past(slv_addr_i[15:0])})
        else $error("short addr");
    idle_quiet_a:
    assert property (!slv_cycle_i |=> !(wide_hit_o || short_hit_o || cfg_hit_o)) else $error("idle");
    page_drive_a:
    assert property (mst_active_i |=> !ad_upper_oe_n_o) else $error("drive");
    page_off_a:
    assert property (!mst_active_i |=> ad_upper_oe_n_o) else $error("release");
    cover property (wide_hit_o);
    cover property (short_hit_o);
    cover property (cfg_hit_o);
endmodule // bwm_props
bind bridge_window_mapping bwm_props u_props (.*);
`default_nettype wire

// [tb/exp_bus_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module exp_bus_far_end (
    input wire logic clk_i, go_i, wide_i, mst_i,
    input wire logic [23:0] addr_i,
    output logic cyc_o, wide_o, mst_o,
    output logic [23:0] addr_o
);
    initial addr_o = 24'h000000;
    // Address lines wander while no cycle is under way
    always @(posedge clk_i) begin
        cyc_o <= go_i;
        wide_o <= wide_i;
        mst_o <= mst_i;
        addr_o <= go_i ? addr_i : ~addr_o;
    end
endmodule // exp_bus_far_end
`default_nettype wire

// [tb/bridge_window_mapping_test.sv]
`timescale 1ns/1ps
`default_nettype none
module bridge_window_mapping_test;
    logic clk_i = 0, rst_n_i = 0, io_wr_i = 0, io_byte_i = 0, go = 0, wide = 0, mst = 0;
    logic [3:0] io_addr_i = 4'h0;
    logic [15:0] io_data_i = 16'h0000;
    logic [23:0] addr = 24'h000000;
    wire slv_cycle_i, slv_wide_i, mst_active_i, wide_hit_o, short_hit_o, cfg_hit_o;
    wire host_mem_o, host_io_o, ad_upper_oe_n_o;
    wire [23:0] slv_addr_i, host_addr_o;
    wire [15:0] ad_upper_o;
    int failures = 0, samples_checked = 0, cycles = 0;
    exp_bus_far_end far (.clk_i(clk_i), .go_i(go), .wide_i(wide), .mst_i(mst), .addr_i(addr),
        .cyc_o(slv_cycle_i), .wide_o(slv_wide_i), .mst_o(mst_active_i), .addr_o(slv_addr_i));
    bridge_window_mapping uut (.*);
    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input [23:0] got, input [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input [3:0] a, input b, input [15:0] d);
        @(posedge clk_i);
        io_wr_i <= 1'b1;
        io_addr_i <= a;
        io_byte_i <= b;
        io_data_i <= d;
        @(posedge clk_i);
        io_wr_i <= 1'b0;
    endtask
    // One slave cycle; hit flags are wide, short, config
    task automatic cyc(input w, input [23:0] a, input [2:0] h, input [23:0] ha);
        @(posedge clk_i);
        go <= 1'b1;
        wide <= w;
        addr <= a;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        #1;
        chk({wide_hit_o, short_hit_o, cfg_hit_o}, h);
        if (h[2:1] != 2'b00) chk(host_addr_o, ha);
    endtask
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(1, 24'h912345, 3'h0, 0);
        cyc(0, 24'h00C123, 3'h1, 0);
        cyc(0, 24'h004ABC, 3'h0, 0);
        wr(4'h0, 0, 16'h8040);
        wr(4'h2, 0, 16'h0F9A);
        cyc(1, 24'h912345, 3'h4, 24'h812345);
        cyc(1, 24'h112345, 3'h0, 0);
        cyc(0, 24'h004ABC, 3'h2, 24'h004ABC);
        cyc(0, 24'h008ABC, 3'h0, 0);
        wr(4'h6, 0, 16'h0000);
        wr(4'h3, 1, 16'h0001);
        cyc(1, 24'h912345, 3'h4, 24'hA12345);
        wr(4'h2, 1, 16'h0000);
        cyc(1, 24'h912345, 3'h0, 0);
        wr(4'h4, 0, 16'hA55A);
        wr(4'h5, 1, 16'h003C);
        mst <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk({ad_upper_oe_n_o, ad_upper_o}, 24'h003C5A);
        @(posedge clk_i);
        mst <= 1'b0;
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        wr(4'h2, 1, 16'h0080);
        cyc(1, 24'h912345, 3'h4, 24'h912345);
        give_verdict();
    end
endmodule // bridge_window_mapping_test
`default_nettype wire
